// ===== shared/crf_defs.svh
// constants for the two receive message fifos of the can controller
// assumes inclusion by name from the package and the design files
//
// Overview of operation
// - two shared receive fifos, each holding up to its configured depth
// - each stored message increments that fifo's six-bit message count
// - full flag set when message count equals depth from depth field
// - empty flag set once all stored messages have been read out
// - messages are read in arrival order, oldest unread always visible
// - read window registers readable only when page select holds page one
// - standard identifier occupies bits 10-0, upper identifier bits read zero
// - classical frames read bitrate switch and error state bits as zero
// - dlc check and replace both set: store rule dlc, else received dlc
// - store rule label pointer and both label flags with each message
// - bytes past dlc read zero; reader stays inside payload size
// - writing all ones to pointer control retires current message
// - disabling a fifo leaves its interrupt request flag set
// - each fifo has its own interrupt enable gating its request
// - mode zero: request when fill reaches threshold plus one eighths, 111 is full
// - mode one: request for every single stored message
// - message lost raises global error interrupt when its enable is set
`ifndef CRF_DEFS_SVH
`define CRF_DEFS_SVH

`define CRF_NUM_FIFOS 2
`define CRF_FIFO_DEPTH 16
`define CRF_CNT_W 6
`define CRF_DATA_BYTES 64
`define CRF_PAGE_FIFO 2'h1
`define CRF_PTR_RETIRE 8'hff

// depth field codes in messages; codes above 011 are capped by storage
`define CRF_DEPTH_C0 6'h00
`define CRF_DEPTH_C1 6'h04
`define CRF_DEPTH_C2 6'h08
`define CRF_DEPTH_C3 6'h10
`define CRF_DEPTH_MAX 6'h10

// payload size codes in bytes
`define CRF_PLS_C0 7'h08
`define CRF_PLS_C1 7'h0c
`define CRF_PLS_C2 7'h10
`define CRF_PLS_C3 7'h14
`define CRF_PLS_C4 7'h18
`define CRF_PLS_C5 7'h20
`define CRF_PLS_C6 7'h30
`define CRF_PLS_C7 7'h40

`endif

// ===== shared/crf_pkg.sv
// types shared by the receive fifo block
// assumes crf_defs.svh is reachable on the include path
`include "crf_defs.svh"

package crf_pkg;

    typedef struct packed {
        logic [28:0] id;
        logic ide;
        logic rtr;
        logic fdf;
        logic brs;
        logic esi;
        logic [3:0] dlc;
        logic [15:0] label_ptr;
        logic label_flag0;
        logic label_flag1;
        logic [`CRF_DATA_BYTES*8-1:0] data;
    } crf_msg_t;

endpackage

// ===== hdl/crf_fifo.sv
// flip-flop fifo with valid and ready on both sides and a flush
// assumes one clock and a synchronous active-high reset
`timescale 1ns/1ps

module crf_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 16
) (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    input wire logic i_flush,
    input wire logic i_in_valid,
    output logic o_in_ready,
    input wire logic [WIDTH-1:0] i_in_data,
    output logic o_out_valid,
    input wire logic i_out_ready,
    output logic [WIDTH-1:0] o_out_data,
    output logic [$clog2(DEPTH):0] o_count
);
    localparam int AW = $clog2(DEPTH);
    localparam logic [AW-1:0] LAST = AW'(DEPTH - 1);
    localparam logic [AW:0] FULL = (AW+1)'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [WIDTH-1:0] next_mem [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic [AW-1:0] next_wr_ptr;
    logic [AW-1:0] next_rd_ptr;
    logic [AW:0] next_count;
    logic push;
    logic pop;

    assign o_in_ready = (count != FULL);
    assign o_out_valid = (count != '0);
    // head is read straight from storage, so it is the oldest entry
    assign o_out_data = mem[rd_ptr];
    assign o_count = count;
    assign push = i_in_valid && o_in_ready;
    assign pop = o_out_valid && i_out_ready;

    always_comb
    begin
        next_mem = mem;
        next_wr_ptr = wr_ptr;
        next_rd_ptr = rd_ptr;
        next_count = count;
        if (push)
        begin
            next_mem[wr_ptr] = i_in_data;
            next_wr_ptr = (wr_ptr == LAST) ? '0 : wr_ptr + 1'b1;
        end
        if (pop)
        begin
            next_rd_ptr = (rd_ptr == LAST) ? '0 : rd_ptr + 1'b1;
        end
        if (push && !pop)
        begin
            next_count = count + 1'b1;
        end
        else if (pop && !push)
        begin
            next_count = count - 1'b1;
        end
        if (i_flush)
        begin
            next_wr_ptr = '0;
            next_rd_ptr = '0;
            next_count = '0;
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        mem <= next_mem;
        if (i_sys_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            wr_ptr <= next_wr_ptr;
            rd_ptr <= next_rd_ptr;
            count <= next_count;
        end
    end

endmodule

// ===== hdl/crf_rx_fifos.sv
// two receive message fifos with status, interrupt flags and a read window
// assumes the filter supplies one message per valid cycle with its rule data
`timescale 1ns/1ps
`include "crf_defs.svh"

module crf_rx_fifos (
    input wire logic i_ref_clk,
    input wire logic i_sys_rst,
    // store side, from the rule filter
    input wire logic i_rx_valid,
    output logic o_rx_ready,
    input wire logic i_rx_fifo_sel,
    input wire logic [28:0] i_rx_id,
    input wire logic i_rx_ide,
    input wire logic i_rx_rtr,
    input wire logic i_rx_fdf,
    input wire logic i_rx_brs,
    input wire logic i_rx_esi,
    input wire logic [3:0] i_rx_dlc,
    input wire logic [511:0] i_rx_data,
    input wire logic [3:0] i_rule_dlc_value,
    input wire logic [15:0] i_rule_label_pointer,
    input wire logic i_rule_label_flag0,
    input wire logic i_rule_label_flag1,
    // global configuration and control
    input wire logic i_dlc_check_enable,
    input wire logic i_dlc_replace_enable,
    input wire logic i_msg_lost_irq_enable,
    // per fifo configuration
    input wire logic [1:0] i_fifo_enable_bit,
    input wire logic [1:0][2:0] i_fifo_depth_select,
    input wire logic [1:0][2:0] i_fifo_payload_size,
    input wire logic [1:0] i_fifo_irq_enable,
    input wire logic [1:0] i_fifo_irq_mode,
    input wire logic [1:0][2:0] i_fifo_irq_threshold,
    input wire logic [1:0] i_irq_flag_clear,
    input wire logic [1:0] i_lost_flag_clear,
    // per fifo status and the global error interrupt
    output logic [1:0][5:0] o_fifo_message_count,
    output logic [1:0] o_fifo_full_flag,
    output logic [1:0] o_fifo_empty_flag,
    output logic [1:0] o_fifo_irq_request_flag,
    output logic [1:0] o_fifo_msg_lost_flag,
    output logic o_global_error_irq,
    // read window
    input wire logic [1:0] i_access_page_select,
    input wire logic i_rd_fifo_sel,
    input wire logic [3:0] i_rd_word_index,
    input wire logic i_ptr_write,
    input wire logic i_ptr_fifo_sel,
    input wire logic [7:0] i_fifo_pointer_control,
    output logic [28:0] o_fifo_identifier_field,
    output logic o_id_extended,
    output logic o_id_remote,
    output logic o_fd_format_flag,
    output logic o_bitrate_switch_flag,
    output logic o_error_state_flag,
    output logic [3:0] o_fifo_stored_dlc,
    output logic [15:0] o_rule_label_pointer,
    output logic o_rule_label_flag0,
    output logic o_rule_label_flag1,
    output logic [31:0] o_data_word
);
    localparam int MW = $bits(crf_pkg::crf_msg_t);

    // ****************************************************************
    // helpers
    // ****************************************************************
    function automatic logic [5:0] depth_of(input logic [2:0] code);
        unique case (code)
            3'h0: depth_of = `CRF_DEPTH_C0;
            3'h1: depth_of = `CRF_DEPTH_C1;
            3'h2: depth_of = `CRF_DEPTH_C2;
            3'h3: depth_of = `CRF_DEPTH_C3;
            // larger codes cannot be backed by sixteen slots
            default: depth_of = `CRF_DEPTH_MAX;
        endcase
    endfunction

    function automatic logic [6:0] payload_bytes(input logic [2:0] code);
        unique case (code)
            3'h0: payload_bytes = `CRF_PLS_C0;
            3'h1: payload_bytes = `CRF_PLS_C1;
            3'h2: payload_bytes = `CRF_PLS_C2;
            3'h3: payload_bytes = `CRF_PLS_C3;
            3'h4: payload_bytes = `CRF_PLS_C4;
            3'h5: payload_bytes = `CRF_PLS_C5;
            3'h6: payload_bytes = `CRF_PLS_C6;
            3'h7: payload_bytes = `CRF_PLS_C7;
        endcase
    endfunction

    function automatic logic [6:0] dlc_bytes(input logic [3:0] dlc);
        unique case (dlc)
            4'h9: dlc_bytes = `CRF_PLS_C1;
            4'ha: dlc_bytes = `CRF_PLS_C2;
            4'hb: dlc_bytes = `CRF_PLS_C3;
            4'hc: dlc_bytes = `CRF_PLS_C4;
            4'hd: dlc_bytes = `CRF_PLS_C5;
            4'he: dlc_bytes = `CRF_PLS_C6;
            4'hf: dlc_bytes = `CRF_PLS_C7;
            default: dlc_bytes = {3'h0, dlc};
        endcase
    endfunction

    // eighths of the depth; a fraction rounds down
    function automatic logic [5:0] irq_level(input logic [5:0] depth,
                                             input logic [2:0] thr);
        logic [8:0] prod;
        prod = {3'h0, depth} * {5'h0, {1'b0, thr} + 4'h1};
        irq_level = prod[8:3];
    endfunction

    // ****************************************************************
    // store path
    // ****************************************************************
    crf_pkg::crf_msg_t in_msg;
    logic [1:0][MW-1:0] head_raw;
    logic [1:0][4:0] raw_count;
    logic [1:0] in_ready;
    logic [1:0] push;
    logic [1:0] pop;
    logic [1:0] lost_evt;
    logic [1:0] logical_full;
    logic [1:0][5:0] count;
    logic [1:0][5:0] depth;

    always_comb
    begin
        in_msg.id = i_rx_ide ? i_rx_id : {18'h0, i_rx_id[10:0]};
        in_msg.ide = i_rx_ide;
        in_msg.rtr = i_rx_rtr;
        in_msg.fdf = i_rx_fdf;
        in_msg.brs = i_rx_fdf && i_rx_brs;
        in_msg.esi = i_rx_fdf && i_rx_esi;
        in_msg.dlc = (i_dlc_check_enable && i_dlc_replace_enable) ?
                     i_rule_dlc_value : i_rx_dlc;
        in_msg.label_ptr = i_rule_label_pointer;
        in_msg.label_flag0 = i_rule_label_flag0;
        in_msg.label_flag1 = i_rule_label_flag1;
        in_msg.data = i_rx_data;
    end

    // ready is always high unless storage refuses; a full fifo drops
    assign o_rx_ready = in_ready[i_rx_fifo_sel] ||
                        logical_full[i_rx_fifo_sel] ||
                        !i_fifo_enable_bit[i_rx_fifo_sel];

    for (genvar k = 0; k < `CRF_NUM_FIFOS; k++)
    begin : g_fifo
        logic sel_in;
        assign depth[k] = depth_of(i_fifo_depth_select[k]);
        assign count[k] = {1'b0, raw_count[k]};
        assign logical_full[k] = (count[k] == depth[k]);
        assign sel_in = i_rx_valid && (i_rx_fifo_sel == 1'(k)) &&
                        i_fifo_enable_bit[k];
        assign push[k] = sel_in && !logical_full[k];
        assign lost_evt[k] = sel_in && logical_full[k];
        assign pop[k] = i_ptr_write && (i_ptr_fifo_sel == 1'(k)) &&
                        (i_fifo_pointer_control == `CRF_PTR_RETIRE) &&
                        i_fifo_enable_bit[k] &&
                        (count[k] != 6'h00);

        // a disabled fifo is flushed, so re-enabling starts empty
        crf_fifo #(
            .WIDTH(MW),
            .DEPTH(`CRF_FIFO_DEPTH)
        ) u_store (
            .i_ref_clk(i_ref_clk),
            .i_sys_rst(i_sys_rst),
            .i_flush(!i_fifo_enable_bit[k]),
            .i_in_valid(push[k]),
            .o_in_ready(in_ready[k]),
            .i_in_data(in_msg),
            .o_out_valid(),
            .i_out_ready(pop[k]),
            .o_out_data(head_raw[k]),
            .o_count(raw_count[k])
        );
    end

    // ****************************************************************
    // status and interrupt flags
    // ****************************************************************
    logic [1:0] irq_flag;
    logic [1:0] lost_flag;
    logic global_err;
    logic [1:0] next_irq_flag;
    logic [1:0] next_lost_flag;
    logic next_global_err;

    always_comb
    begin
        next_irq_flag = irq_flag;
        next_lost_flag = lost_flag;
        for (int k = 0; k < `CRF_NUM_FIFOS; k++)
        begin
            // clear comes first so a coincident set wins
            if (i_irq_flag_clear[k])
            begin
                next_irq_flag[k] = 1'b0;
            end
            if (i_lost_flag_clear[k])
            begin
                next_lost_flag[k] = 1'b0;
            end
            // flag is set only while the interrupt enable is on, never cleared by it
            if (push[k] && i_fifo_irq_enable[k])
            begin
                if (i_fifo_irq_mode[k])
                begin
                    next_irq_flag[k] = 1'b1;
                end
                else if (count[k] + 6'h01 ==
                         irq_level(depth[k], i_fifo_irq_threshold[k]))
                begin
                    next_irq_flag[k] = 1'b1;
                end
            end
            if (lost_evt[k])
            begin
                next_lost_flag[k] = 1'b1;
            end
        end
        next_global_err = i_msg_lost_irq_enable && (|lost_flag);
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            irq_flag <= 2'h0;
            lost_flag <= 2'h0;
            global_err <= 1'b0;
        end
        else
        begin
            irq_flag <= next_irq_flag;
            lost_flag <= next_lost_flag;
            global_err <= next_global_err;
        end
    end

    assign o_fifo_message_count = count;
    assign o_fifo_full_flag = logical_full;
    assign o_fifo_empty_flag = {count[1] == 6'h00,
                                count[0] == 6'h00};
    assign o_fifo_irq_request_flag = irq_flag;
    assign o_fifo_msg_lost_flag = lost_flag;
    assign o_global_error_irq = global_err;

    // ****************************************************************
    // read window
    // ****************************************************************
    crf_pkg::crf_msg_t head;
    crf_pkg::crf_msg_t win;
    crf_pkg::crf_msg_t next_win;
    logic [31:0] win_data;
    logic [31:0] next_win_data;
    logic [6:0] limit;
    logic [6:0] byte_idx;

    always_comb
    begin
        head = crf_pkg::crf_msg_t'(head_raw[i_rd_fifo_sel]);
        limit = dlc_bytes(head.dlc);
        if (payload_bytes(i_fifo_payload_size[i_rd_fifo_sel]) < limit)
        begin
            limit = payload_bytes(i_fifo_payload_size[i_rd_fifo_sel]);
        end
        next_win = '0;
        next_win_data = 32'h0;
        byte_idx = 7'h00;
        if ((i_access_page_select == `CRF_PAGE_FIFO) &&
            (count[i_rd_fifo_sel] != 6'h00))
        begin
            next_win = head;
            next_win.data = '0;
            for (int b = 0; b < 4; b++)
            begin
                byte_idx = {1'b0, i_rd_word_index, 2'(b)};
                if (byte_idx < limit)
                begin
                    next_win_data[b*8 +: 8] = head.data[byte_idx*8 +: 8];
                end
            end
        end
    end

    always_ff @(posedge i_ref_clk)
    begin
        if (i_sys_rst)
        begin
            win <= '0;
            win_data <= 32'h0;
        end
        else
        begin
            win <= next_win;
            win_data <= next_win_data;
        end
    end

    assign o_fifo_identifier_field = win.id;
    assign o_id_extended = win.ide;
    assign o_id_remote = win.rtr;
    assign o_fd_format_flag = win.fdf;
    assign o_bitrate_switch_flag = win.brs;
    assign o_error_state_flag = win.esi;
    assign o_fifo_stored_dlc = win.dlc;
    assign o_rule_label_pointer = win.label_ptr;
    assign o_rule_label_flag0 = win.label_flag0;
    assign o_rule_label_flag1 = win.label_flag1;
    assign o_data_word = win_data;

    // ****************************************************************
    // checks
    // ****************************************************************
    for (genvar k = 0; k < `CRF_NUM_FIFOS; k++)
    begin : g_chk
        store_count_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            push[k] && !pop[k] && i_fifo_enable_bit[k] ##1
            i_fifo_enable_bit[k] |-> count[k] == $past(count[k]) + 6'h01)
            else $error("count did not rise on store");
        retire_count_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            pop[k] && !push[k] ##1 i_fifo_enable_bit[k]
            |-> count[k] == $past(count[k]) - 6'h01)
            else $error("count did not fall on retire");
        full_cause_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            $rose(o_fifo_full_flag[k]) && depth[k] != 6'h00 &&
            $stable(depth[k]) |-> $past(push[k]))
            else $error("full flag rose without a store");
        lost_keep_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            lost_evt[k] && !pop[k] |=> lost_flag[k] &&
            count[k] == $past(count[k]))
            else $error("dropped message not flagged or stored");
        irq_hold_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            irq_flag[k] && !i_irq_flag_clear[k] |=> irq_flag[k])
            else $error("request flag lost without a clear");
        every_msg_irq_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            push[k] && i_fifo_irq_mode[k] && i_fifo_irq_enable[k]
            |=> irq_flag[k])
            else $error("per message request missing");
        irq_gate_a: assert property (
            @(posedge i_ref_clk) disable iff (i_sys_rst)
            !i_fifo_irq_enable[k] && !irq_flag[k] |=> !irq_flag[k])
            else $error("request raised while disabled");
    end

    page_gate_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        i_access_page_select != `CRF_PAGE_FIFO |=>
        o_fifo_identifier_field == 29'h0 && o_data_word == 32'h0)
        else $error("window readable outside page one");
    std_id_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !o_id_extended |-> o_fifo_identifier_field[28:11] == 18'h0)
        else $error("standard id has upper bits set");
    classic_fd_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        !o_fd_format_flag |-> !o_bitrate_switch_flag && !o_error_state_flag)
        else $error("classic frame shows fd status bits");
    global_err_a: assert property (
        @(posedge i_ref_clk) disable iff (i_sys_rst)
        (|lost_flag) && i_msg_lost_irq_enable |=> o_global_error_irq)
        else $error("message lost did not raise global error");

endmodule

// ===== testbench/crf_filter_model.sv
// filter side model: offers one message per call at the store port
// assumes offer is called from a falling edge of i_ref_clk
`timescale 1ns/1ps
module crf_filter_model (
    input wire logic i_ref_clk,
    input wire logic i_rx_ready,
    output logic o_valid,
    output logic o_sel,
    output logic [28:0] o_id,
    output logic o_ide,
    output logic o_rtr,
    output logic o_fdf,
    output logic o_brs,
    output logic o_esi,
    output logic [3:0] o_dlc,
    output logic [511:0] o_data,
    output logic [3:0] o_rdlc,
    output logic [15:0] o_lptr,
    output logic o_lf0,
    output logic o_lf1
);
    initial
    begin
        o_valid = 1'b0;
        {o_sel, o_id, o_ide, o_rtr, o_fdf, o_brs, o_esi} = '0;
        {o_dlc, o_data, o_rdlc, o_lptr, o_lf0, o_lf1} = '0;
    end
    // *****
    // offer
    // *****
    // brs and esi go high always, so classical frames must mask them
    task automatic offer(input logic s, input logic [28:0] id,
        input logic f, input logic [3:0] d);
        int n;
        logic rdy;
        @(negedge i_ref_clk);
        o_valid = 1'b1;
        {o_sel, o_id, o_ide, o_rtr, o_fdf} = {s, id, id[4], id[4], f};
        {o_brs, o_esi, o_dlc} = {2'h3, d};
        {o_rdlc, o_lptr} = {4'hf - d, ~id[15:0]};
        {o_lf0, o_lf1} = {id[0], ~id[0]};
        for (n = 0; n < 64; n++)
            o_data[8*n+:8] = 8'(n) + id[7:0];
        // ready is taken before the edge; a stall for good ends at the
        // bench watchdog, which counts it as a mismatch
        do
        begin
            rdy = (i_rx_ready === 1'b1);
            @(posedge i_ref_clk);
        end
        while (!rdy);
        @(negedge i_ref_clk);
        o_valid = 1'b0;
        // released fields flip so a stale message is never seen as valid
        {o_sel, o_id, o_dlc, o_data} = ~{o_sel, o_id, o_dlc, o_data};
        {o_ide, o_rtr, o_fdf} = ~{o_ide, o_rtr, o_fdf};
    endtask
endmodule

// ===== testbench/crf_rx_fifos_tb.sv
// self-checking bench for the two receive message fifos
// assumes the filter model feeds the store side; inputs move at negedge
`timescale 1ns/1ps
module crf_rx_fifos_tb;
    logic i_ref_clk, i_sys_rst, i_rx_valid, o_rx_ready, i_rx_fifo_sel;
    logic i_rx_ide, i_rx_rtr, i_rx_fdf, i_rx_brs, i_rx_esi, i_ptr_write;
    logic [28:0] i_rx_id, o_fifo_identifier_field;
    logic [3:0] i_rx_dlc, i_rule_dlc_value, i_rd_word_index;
    logic [3:0] o_fifo_stored_dlc;
    logic [511:0] i_rx_data;
    logic [15:0] i_rule_label_pointer, o_rule_label_pointer;
    logic i_rule_label_flag0, i_rule_label_flag1, i_dlc_check_enable;
    logic i_dlc_replace_enable, i_msg_lost_irq_enable, o_global_error_irq;
    logic [1:0] i_fifo_enable_bit, i_fifo_irq_enable, i_fifo_irq_mode;
    logic [1:0] i_irq_flag_clear, i_lost_flag_clear, i_access_page_select;
    logic [1:0] o_fifo_full_flag, o_fifo_empty_flag, o_fifo_irq_request_flag;
    logic [1:0] o_fifo_msg_lost_flag;
    logic [1:0][2:0] i_fifo_depth_select, i_fifo_payload_size;
    logic [1:0][2:0] i_fifo_irq_threshold;
    logic [1:0][5:0] o_fifo_message_count;
    logic i_rd_fifo_sel, i_ptr_fifo_sel, o_id_extended, o_id_remote;
    logic o_fd_format_flag, o_bitrate_switch_flag, o_error_state_flag;
    logic o_rule_label_flag0, o_rule_label_flag1;
    logic [7:0] i_fifo_pointer_control;
    logic [31:0] o_data_word;
    int mismatches, total_checks;

    crf_rx_fifos crf_rx_fifos_i (.*);
    crf_filter_model crf_filter_model_i (
        .i_ref_clk, .i_rx_ready(o_rx_ready), .o_valid(i_rx_valid),
        .o_sel(i_rx_fifo_sel), .o_id(i_rx_id), .o_ide(i_rx_ide),
        .o_rtr(i_rx_rtr), .o_fdf(i_rx_fdf), .o_brs(i_rx_brs),
        .o_esi(i_rx_esi), .o_dlc(i_rx_dlc), .o_data(i_rx_data),
        .o_rdlc(i_rule_dlc_value), .o_lptr(i_rule_label_pointer),
        .o_lf0(i_rule_label_flag0), .o_lf1(i_rule_label_flag1)
    );
    // *****
    // tasks
    // *****
    task automatic chk(input logic [63:0] g, input logic [63:0] e);
        total_checks++;
        if (g !== e)
        begin
            mismatches++;
            $display("[FAIL] %0t got %h want %h", $time, g, e);
        end
    endtask
    task automatic pop(input logic s, input logic [7:0] v);
        {i_ptr_write, i_ptr_fifo_sel, i_fifo_pointer_control} = {1'b1, s, v};
        @(negedge i_ref_clk);
        i_ptr_write = 1'b0;
        @(negedge i_ref_clk);
    endtask
    task automatic win(input logic [1:0] p, input logic [3:0] w);
        {i_access_page_select, i_rd_word_index} = {p, w};
        @(negedge i_ref_clk);
    endtask
    task automatic t_fill;
        chk(o_fifo_empty_flag, 2'h3);
        for (int k = 0; k < 4; k++)
        begin
            crf_filter_model_i.offer(1'b0, 29'h1abcd001 + k, 1'b0, 4'h2);
            chk(o_fifo_message_count[0], 6'(k + 1));
            chk(o_fifo_full_flag[0], k == 3);
            chk(o_fifo_irq_request_flag[0], k == 3);
        end
        crf_filter_model_i.offer(1'b0, 29'h1abcd009, 1'b0, 4'h2);
        chk({o_fifo_message_count[0], o_fifo_msg_lost_flag}, 8'h11);
        @(negedge i_ref_clk);
        chk(o_global_error_irq, 1'b1);
        i_lost_flag_clear = 2'h1;
        @(negedge i_ref_clk);
        i_lost_flag_clear = 2'h0;
        @(negedge i_ref_clk);
        chk({o_fifo_msg_lost_flag, o_global_error_irq}, 3'h0);
    endtask
    task automatic t_window;
        i_rd_fifo_sel = 1'b0;
        win(2'h0, 4'h0);
        chk(o_fifo_identifier_field, 29'h0);
        win(2'h1, 4'h0);
        chk(o_fifo_identifier_field, 29'h1);
        chk({o_id_extended, o_id_remote, o_rule_label_flag1}, 3'h0);
        chk({o_bitrate_switch_flag, o_error_state_flag}, 2'h0);
        chk(o_fifo_stored_dlc, 4'h2);
        chk({o_rule_label_pointer, o_rule_label_flag0}, 17'h05ffd);
        chk(o_data_word, 32'h00000201);
        pop(1'b0, 8'h7f);
        chk(o_fifo_message_count[0], 6'h04);
        pop(1'b0, 8'hff);
        chk(o_fifo_identifier_field, 29'h2);
        repeat (3) pop(1'b0, 8'hff);
        chk(o_fifo_empty_flag[0], 1'b1);
    endtask
    task automatic t_irq;
        {i_dlc_check_enable, i_dlc_replace_enable, i_rd_fifo_sel} = 3'h7;
        for (int k = 0; k < 4; k++)
        begin
            crf_filter_model_i.offer(1'b1, 29'h10 + k, 1'b1, 4'h9);
            chk(o_fifo_irq_request_flag[1], k == 3);
        end
        win(2'h1, 4'h0);
        chk(o_fifo_identifier_field, 29'h10);
        chk({o_id_extended, o_id_remote, o_rule_label_flag1}, 3'h7);
        chk({o_fifo_stored_dlc, o_fd_format_flag, o_error_state_flag},
            6'h1b);
        win(2'h1, 4'h3);
        chk(o_data_word, 32'h0);
        i_irq_flag_clear = 2'h2;
        i_fifo_irq_mode[1] = 1'b1;
        @(negedge i_ref_clk);
        i_irq_flag_clear = 2'h0;
        crf_filter_model_i.offer(1'b1, 29'h20, 1'b0, 4'h1);
        chk(o_fifo_irq_request_flag[1], 1'b1);
        {i_irq_flag_clear, i_fifo_irq_enable} = {2'h2, 2'h1};
        @(negedge i_ref_clk);
        i_irq_flag_clear = 2'h0;
        crf_filter_model_i.offer(1'b1, 29'h21, 1'b0, 4'h1);
        chk(o_fifo_irq_request_flag[1], 1'b0);
        i_fifo_irq_enable = 2'h3;
        crf_filter_model_i.offer(1'b1, 29'h22, 1'b0, 4'h1);
        i_fifo_enable_bit[1] = 1'b0;
        repeat (2) @(negedge i_ref_clk);
        chk(o_fifo_irq_request_flag[1], 1'b1);
    endtask
    task automatic complete_run;
        if (mismatches == 0 && total_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // ****
    // flow
    // ****
    initial
    begin
        i_ref_clk = 1'b0;
        forever #5 i_ref_clk = ~i_ref_clk;
    end
    initial
    begin
        #20us;
        mismatches++;
        complete_run();
    end
    initial
    begin
        i_sys_rst = 1'b1;
        {i_ptr_write, i_ptr_fifo_sel, i_rd_fifo_sel} = '0;
        {i_fifo_pointer_control, i_access_page_select} = '0;
        {i_rd_word_index, i_irq_flag_clear, i_lost_flag_clear} = '0;
        {i_dlc_check_enable, i_dlc_replace_enable} = 2'h0;
        {i_msg_lost_irq_enable, i_fifo_irq_mode} = 3'h4;
        {i_fifo_irq_enable, i_fifo_enable_bit} = 4'hf;
        i_fifo_depth_select = {3'h2, 3'h1};
        i_fifo_payload_size = {3'h7, 3'h0};
        i_fifo_irq_threshold = {3'h3, 3'h7};
        repeat (20) @(negedge i_ref_clk);
        i_sys_rst = 1'b0;
        t_fill();
        t_window();
        t_irq();
        complete_run();
    end
endmodule
